// ===== common/link_selftest_pkg.sv
// Purpose: shared constants and types for the link self-test block
// Assumes: 32-bit link data, one word per system clock
// Notes:   register map is word aligned on AHB-Lite
package link_selftest_pkg;

    localparam int DATA_W = 32;

    // width select codes
    localparam logic [1:0] WSEL_32 = 2'h0;
    localparam logic [1:0] WSEL_16 = 2'h1;
    localparam logic [1:0] WSEL_8  = 2'h2;

    // highest walking-one index per width
    localparam logic [5:0] LAST_32 = 6'h20;
    localparam logic [5:0] LAST_16 = 6'h10;
    localparam logic [5:0] LAST_8  = 6'h08;

    // return channel: consecutive bad words that break a 16-cycle pulse
    localparam logic [4:0] RET_FAIL_CNT = 5'h10;
    // test request low to link down low, in clock cycles
    localparam int TEST_LD_MAX_CYC = 4;
    // cycles after reset release at which width select is sampled
    localparam logic [1:0] CFG_SAMPLE_CYC = 2'h2;

    // register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    // field positions
    localparam int CTRL_ERR_CLR_BIT = 0;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    // word in flight on the forward link
    typedef struct packed {
        logic        test;
        logic        valid;
        logic        ctrl_n;
        logic [31:0] data;
        logic        par;
    } fwd_word_t;

    // word in flight on the return link
    typedef struct packed {
        logic [3:0] lines;
        logic       par;
    } ret_word_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PREP = 2'b01,
        ST_RUN  = 2'b10
    } test_state_t;

endpackage : link_selftest_pkg

// ===== hdl/link_selftest_return_width.sv
// Purpose: self-test pattern, return lines and width select of the link
// Assumes: clock is the source clock; dest_clock is sampled as an input
// Notes:   the physical link is modelled as one register stage each way
// Notes on behaviour
// - source mirrors four return inputs on outputs
// - delivered return pulses last at least 16
// - bad return word leaves outputs unchanged
// - persistent return errors drop source link down
// - return lines run in test, low in reset
// - width codes 32/16/8, code 11 reserved
// - width sampled once after reset release
// - unused upper inputs ignored, outputs grounded
// - test request low enters test mode
// - zero word ctrl low, then walking one
// - pattern cycle length is width plus one
// - destination checks pattern, latches data error
// - pulse gives one cycle, finish on release
// - link down low within 4 cycles
// - write enable off in test unless forwarded
// - flow stop pauses pattern only when forwarding
// - clear errors and buffers on test edges
// - return channel errors in test mode also latch data error
// - link down low throughout test mode
// - destination link down leads first test word
// - link down releases automatically after test
//
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
module link_selftest_return_width (
    // system
    input  wire logic        clock,
    input  wire logic        nrst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // front-end board side of the source card
    input  wire logic        test_request_n,
    input  wire logic        source_write_en_n,
    input  wire logic [31:0] source_data,
    input  wire logic [1:0]  width_select,
    output logic             src_link_down_n,
    output logic             src_test_led,
    output logic      [3:0]  return_out,
    // readout board side of the destination card
    input  wire logic        dest_clock,
    input  wire logic        test_forward_n,
    input  wire logic        flow_stop_n,
    input  wire logic [3:0]  return_in,
    output logic             dst_link_down_n,
    output logic             dst_test_led,
    output logic             data_error_n,
    output logic             dest_write_en_n,
    output logic             control_flag_n,
    output logic      [31:0] dest_data,
    // physical link error injection
    input  wire logic        fwd_fault,
    input  wire logic        ret_fault
);

    ////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [5:0] last_index(input logic [1:0] code);
        last_index = (code == link_selftest_pkg::WSEL_16) ?
                     link_selftest_pkg::LAST_16 :
                     (code == link_selftest_pkg::WSEL_8) ?
                     link_selftest_pkg::LAST_8 :
                     link_selftest_pkg::LAST_32;
    endfunction : last_index

    function automatic logic [31:0] width_mask(input logic [1:0] code);
        width_mask = (code == link_selftest_pkg::WSEL_16) ? 32'h0000_ffff :
                     (code == link_selftest_pkg::WSEL_8)  ? 32'h0000_00ff :
                     32'hffff_ffff;
    endfunction : width_mask

    // index 0 is the zero word, index n carries a one on bit n-1
    function automatic logic [31:0] walk_word(input logic [5:0] idx);
        logic [5:0] sh;
        sh = idx - 6'h01;
        walk_word = (idx == 6'h00) ? 32'h0000_0000 :
                    (32'h0000_0001 << sh[4:0]);
    endfunction : walk_word

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers: all external levels pass two flops

    localparam int SYNC_W = 45;
    logic [SYNC_W-1:0] pin_s1_reg;
    logic [SYNC_W-1:0] pin_s2_reg;
    wire  [SYNC_W-1:0] pin_raw = {test_request_n, test_forward_n,
                                  flow_stop_n, width_select, return_in,
                                  dest_clock, source_write_en_n,
                                  source_data, fwd_fault, ret_fault};

    always_ff @(posedge clock or negedge nrst)
        if (!nrst)
        begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end
        else
        begin
            pin_s1_reg <= pin_raw;
            pin_s2_reg <= pin_s1_reg;
        end

    wire        req_low   = ~pin_s2_reg[44];
    wire        fwd_on    = ~pin_s2_reg[43];
    wire        flow_stop = ~pin_s2_reg[42];
    wire [1:0]  wsel_s    = pin_s2_reg[41:40];
    wire [3:0]  ret_in_s  = pin_s2_reg[39:36];
    wire        dclk_s    = pin_s2_reg[35];
    wire        src_we    = ~pin_s2_reg[34];
    wire [31:0] src_dat_s = pin_s2_reg[33:2];
    wire        ffault_s  = pin_s2_reg[1];
    wire        rfault_s  = pin_s2_reg[0];

    ////////////////////////////////////////////////////////////////////
    // width configuration, caught once after reset release

    logic [1:0] cfg_cnt_reg;
    logic       cfg_done_reg;
    logic [1:0] width_reg;
    wire        cfg_take = ~cfg_done_reg &
                           (cfg_cnt_reg == link_selftest_pkg::CFG_SAMPLE_CYC);

    // waits for the synchroniser to fill before sampling
    always_ff @(posedge clock or negedge nrst)
        if (!nrst)
        begin
            cfg_cnt_reg  <= 2'h0;
            cfg_done_reg <= 1'b0;
            width_reg    <= link_selftest_pkg::WSEL_32;
        end
        else
        begin
            cfg_cnt_reg  <= cfg_done_reg ? cfg_cnt_reg : cfg_cnt_reg + 2'h1;
            cfg_done_reg <= cfg_done_reg | cfg_take;
            if (cfg_take)
                width_reg <= wsel_s;
        end

    wire [5:0]  last_idx = last_index(width_reg);
    wire [31:0] wmask    = width_mask(width_reg);

    ////////////////////////////////////////////////////////////////////
    // test pattern sequencer (source card)

    link_selftest_pkg::test_state_t state_reg, state_next;
    logic [5:0] idx_reg, idx_next;
    logic       test_q_reg;

    wire test_active = (state_reg != link_selftest_pkg::ST_IDLE);
    wire test_edge   = test_active ^ test_q_reg;
    wire stall       = fwd_on & flow_stop;
    wire wrap        = (idx_reg == last_idx);

    always_comb
    begin
        state_next = state_reg;
        idx_next   = idx_reg;
        case (state_reg)
            link_selftest_pkg::ST_IDLE:
                if (req_low && cfg_done_reg)
                    state_next = link_selftest_pkg::ST_PREP;
            link_selftest_pkg::ST_PREP:
            begin
                state_next = link_selftest_pkg::ST_RUN;
                idx_next   = 6'h00;
            end
            link_selftest_pkg::ST_RUN:
                if (!stall)
                begin
                    if (!wrap)
                        idx_next = idx_reg + 6'h01;
                    else
                    begin
                        idx_next = 6'h00;
                        // a cycle always runs to its end once started
                        if (!req_low)
                            state_next = link_selftest_pkg::ST_IDLE;
                    end
                end
            default:
                state_next = link_selftest_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge nrst)
        if (!nrst)
        begin
            state_reg  <= link_selftest_pkg::ST_IDLE;
            idx_reg    <= 6'h00;
            test_q_reg <= 1'b0;
        end
        else
        begin
            state_reg  <= state_next;
            idx_reg    <= idx_next;
            test_q_reg <= test_active;
        end

    ////////////////////////////////////////////////////////////////////
    // forward link word: test pattern or user data

    link_selftest_pkg::fwd_word_t fwd_reg, fwd_next;
    logic src_ld_n_reg;
    wire sending = (state_reg == link_selftest_pkg::ST_RUN) & ~stall;

    always_comb
    begin
        fwd_next        = '0;
        fwd_next.test   = test_active;
        fwd_next.ctrl_n = 1'b1;
        if (sending)
        begin
            fwd_next.valid  = 1'b1;
            fwd_next.ctrl_n = (idx_reg != 6'h00);
            fwd_next.data   = walk_word(idx_reg);
        end
        else if (!test_active && src_ld_n_reg)
        begin
            fwd_next.valid = src_we;
            fwd_next.data  = src_dat_s & wmask;
        end
        // anything pending is dropped when test mode flips
        if (test_edge)
            fwd_next.valid = 1'b0;
        fwd_next.par = ^{fwd_next.ctrl_n, fwd_next.data} ^ ffault_s;
    end

    always_ff @(posedge clock or negedge nrst)
        if (!nrst)
            fwd_reg <= '0;
        else
            fwd_reg <= fwd_next;

    ////////////////////////////////////////////////////////////////////
    // return channel: sampled on dest_clock edges, checked at source

    logic      dclk_d_reg;
    logic      ret_vld_reg;
    logic      rfail_reg;
    logic [4:0] rerr_cnt_reg;
    logic [3:0] ret_out_reg;
    link_selftest_pkg::ret_word_t ret_reg;

    wire dtick    = dclk_s & ~dclk_d_reg;
    wire ret_good = ~(^{ret_reg.lines, ret_reg.par});
    wire ret_bad  = ret_vld_reg & ~ret_good;
    wire [4:0] rerr_inc = rerr_cnt_reg + 5'h01;

    // one return word per rising destination clock edge
    always_ff @(posedge clock or negedge nrst)
        if (!nrst)
        begin
            dclk_d_reg  <= 1'b0;
            ret_vld_reg <= 1'b0;
            ret_reg     <= '0;
        end
        else
        begin
            dclk_d_reg  <= dclk_s;
            ret_vld_reg <= dtick;
            if (dtick)
            begin
                ret_reg.lines <= ret_in_s;
                ret_reg.par   <= (^ret_in_s) ^ rfault_s;
            end
        end

    // outputs follow good words only; bad words are skipped, so a
    // 32-cycle pulse stays at least 16 long until the fail trips
    always_ff @(posedge clock or negedge nrst)
        if (!nrst)
        begin
            ret_out_reg  <= 4'h0;
            rerr_cnt_reg <= 5'h00;
            rfail_reg    <= 1'b0;
        end
        else if (ret_vld_reg)
        begin
            if (ret_good)
            begin
                ret_out_reg  <= ret_reg.lines;
                rerr_cnt_reg <= 5'h00;
            end
            else
            begin
                rerr_cnt_reg <= rerr_inc;
                if (rerr_inc >= link_selftest_pkg::RET_FAIL_CNT)
                    rfail_reg <= 1'b1;
            end
        end

    ////////////////////////////////////////////////////////////////////
    // source link down and indicator

    // latched return failure clears only by reset; test clears itself
    always_ff @(posedge clock or negedge nrst)
        if (!nrst)
            src_ld_n_reg <= 1'b0;
        else
            src_ld_n_reg <= ~(req_low | test_active | rfail_reg);

    ////////////////////////////////////////////////////////////////////
    // destination card: outputs, pattern check, error latch

    logic        dst_test_reg;
    logic        dst_ld_n_reg;
    logic        we_n_reg;
    logic        ctrl_n_reg;
    logic [31:0] ddata_reg;
    logic [5:0]  dexp_reg;
    logic        err_reg;
    logic        sw_clr;

    wire par_bad  = ~(^{fwd_reg.ctrl_n, fwd_reg.data}) ^ 1'b1 ^
                    fwd_reg.par;
    wire mismatch = (fwd_reg.data != walk_word(dexp_reg)) |
                    (fwd_reg.ctrl_n != (dexp_reg != 6'h00));
    wire chk_word = fwd_reg.valid & fwd_reg.test;
    wire err_set  = (fwd_reg.valid & par_bad) |
                    (chk_word & mismatch) |
                    (fwd_reg.test & ret_bad);
    wire err_clr  = test_edge | sw_clr;
    wire we_now   = fwd_reg.valid & (~fwd_reg.test | fwd_on);

    // a new error wins over a clear in the same cycle
    always_ff @(posedge clock or negedge nrst)
        if (!nrst)
            err_reg <= 1'b0;
        else
            err_reg <= err_set | (err_reg & ~err_clr);

    // expected index restarts on each entry into test mode
    always_ff @(posedge clock or negedge nrst)
        if (!nrst)
            dexp_reg <= 6'h00;
        else if (!fwd_reg.test)
            dexp_reg <= 6'h00;
        else if (chk_word)
            dexp_reg <= (dexp_reg == last_idx) ? 6'h00 : dexp_reg + 6'h01;

    // test flag arrives one cycle ahead of the first word
    always_ff @(posedge clock or negedge nrst)
        if (!nrst)
        begin
            dst_test_reg <= 1'b0;
            dst_ld_n_reg <= 1'b0;
            we_n_reg     <= 1'b1;
            ctrl_n_reg   <= 1'b1;
            ddata_reg    <= 32'h0000_0000;
        end
        else
        begin
            dst_test_reg <= fwd_reg.test;
            dst_ld_n_reg <= ~fwd_reg.test;
            we_n_reg     <= ~we_now;
            if (we_now)
            begin
                ctrl_n_reg <= fwd_reg.ctrl_n;
                ddata_reg  <= fwd_reg.data & wmask;
            end
        end

    ////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait states, always OKAY

    logic        ph_wr_reg;
    logic [7:0]  ph_addr_reg;
    logic [31:0] rdata_reg;

    wire        addr_ph = hsel & htrans[1] & hready;
    wire [31:0] status  = {20'h00000, ret_out_reg, ~dst_ld_n_reg,
                           ~src_ld_n_reg, width_reg, rfail_reg, err_reg,
                           dst_test_reg, test_active};
    wire [31:0] rmux    = (haddr[7:0] == link_selftest_pkg::STATUS_OFS) ?
                          status : link_selftest_pkg::REG_RESET;
    assign sw_clr = ph_wr_reg &
                    (ph_addr_reg == link_selftest_pkg::CTRL_OFS) &
                    hwdata[link_selftest_pkg::CTRL_ERR_CLR_BIT];

    // read data captured in the address phase, shown in the data phase
    always_ff @(posedge clock or negedge nrst)
        if (!nrst)
        begin
            ph_wr_reg   <= 1'b0;
            ph_addr_reg <= 8'h00;
            rdata_reg   <= link_selftest_pkg::REG_RESET;
        end
        else
        begin
            ph_wr_reg   <= addr_ph & hwrite;
            ph_addr_reg <= haddr[7:0];
            if (addr_ph && !hwrite)
                rdata_reg <= rmux;
        end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign hrdata          = rdata_reg;
    assign hreadyout       = 1'b1;
    assign hresp           = 1'b0;
    assign src_link_down_n = src_ld_n_reg;
    assign src_test_led    = test_active;
    assign return_out      = ret_out_reg;
    assign dst_link_down_n = dst_ld_n_reg;
    assign dst_test_led    = dst_test_reg;
    assign data_error_n    = ~err_reg;
    assign dest_write_en_n = we_n_reg;
    assign control_flag_n  = ctrl_n_reg;
    assign dest_data       = ddata_reg;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_cycle_start;
        sending && idx_reg == 6'h00;
    endsequence
    sequence s_zero_out;
        fwd_reg.valid && fwd_reg.data == 32'h0 && !fwd_reg.ctrl_n;
    endsequence
    sequence s_one_out;
        fwd_reg.data == 32'h1 && fwd_reg.ctrl_n;
    endsequence

    chk_zero_first: assert property (
        s_cycle_start ##1 !stall |-> s_zero_out ##1 s_one_out)
        else $error("pattern cycle did not start 0 then 1");
    chk_cycle_len: assert property (
        state_reg == link_selftest_pkg::ST_RUN |-> idx_reg <= last_idx)
        else $error("pattern index beyond width");
    chk_ld_req: assert property (
        $fell(test_request_n) |-> ##[1:4] !src_link_down_n)
        else $error("link down late after test request");
    chk_ld_test: assert property (
        test_q_reg && test_active |-> !src_link_down_n)
        else $error("link down high in test mode");
    chk_ret_hold: assert property (
        ret_bad |=> $stable(return_out))
        else $error("return outputs moved on bad word");
    chk_ret_fail: assert property (
        ret_bad && rerr_cnt_reg == 5'h0f |=> rfail_reg ##1 !src_link_down_n)
        else $error("return failure did not drop link down");
    chk_width_fix: assert property (
        $past(cfg_done_reg) |-> $stable(width_reg))
        else $error("width changed after sampling");
    chk_upper_gnd: assert property (
        (dest_data & ~wmask) == 32'h0)
        else $error("unused data outputs not grounded");
    chk_no_fwd: assert property (
        fwd_reg.test && !fwd_on |=> dest_write_en_n)
        else $error("test word written without forwarding");
    chk_err_hold: assert property (
        err_reg && !err_clr |=> err_reg)
        else $error("data error latch dropped");

endmodule : link_selftest_return_width

// ===== testbench/readout_model.sv
// Purpose: far-side readout board: link clock and return line drivers
// Assumes: link clock runs free at 400 ns, unrelated in phase
// Notes:   a requested return value waits until the last one is old enough
`timescale 1ns/100ps
module readout_model (
    // link side
    output logic       dest_clock,
    output logic [3:0] return_in,
    // bench command
    input  wire logic [3:0] ret_req
);
    int hold_cnt;

    ////////////////////////////////////////////////////////////////////////
    // odd start delay keeps the link clock off the system clock phase
    initial
    begin
        dest_clock = 1'b0;
        return_in  = 4'h0;
        hold_cnt   = 0;
        #37;
        forever #200 dest_clock = ~dest_clock;
    end

    // a new level only after 32 link cycles, so no pulse is cut short
    always @(posedge dest_clock)
    begin
        if (hold_cnt < 32)
            hold_cnt <= hold_cnt + 1;
        else if (ret_req !== return_in)
        begin
            return_in <= ret_req;
            hold_cnt  <= 1;
        end
    end
endmodule : readout_model

// ===== testbench/tb.sv
// Purpose: self-checking bench for the link self-test block
// Assumes: AHB master with single word transfers, 50 ns system clock
// Notes:   expected test words come from an integer model of the pattern
`timescale 1ns/100ps
module tb;
    logic clock = 0, nrst = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, source_data = 0, hrdata, dest_data;
    logic [1:0]  htrans = 0, width_select = 0;
    logic [3:0]  ret_req = 0, return_out, return_in;
    logic test_request_n = 1, source_write_en_n = 1, test_forward_n = 1;
    logic fwd_fault = 0, ret_fault = 0, hreadyout, hresp, dest_clock;
    logic flow_stop_n = 1;
    logic src_link_down_n, src_test_led, dst_link_down_n, dst_test_led;
    logic data_error_n, dest_write_en_n, control_flag_n;
    logic [31:0] q;
    logic [32:0] got[$];
    int err_count = 0, cmp_count = 0, cycles = 0;

    link_selftest_return_width dut (.clock(clock), .nrst(nrst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .test_request_n(test_request_n),
        .source_write_en_n(source_write_en_n), .source_data(source_data),
        .width_select(width_select), .src_link_down_n(src_link_down_n),
        .src_test_led(src_test_led), .return_out(return_out),
        .dest_clock(dest_clock), .test_forward_n(test_forward_n),
        .flow_stop_n(flow_stop_n), .return_in(return_in),
        .dst_link_down_n(dst_link_down_n), .dst_test_led(dst_test_led),
        .data_error_n(data_error_n), .dest_write_en_n(dest_write_en_n),
        .control_flag_n(control_flag_n), .dest_data(dest_data),
        .fwd_fault(fwd_fault), .ret_fault(ret_fault));
    readout_model far (.dest_clock(dest_clock), .return_in(return_in),
        .ret_req(ret_req));

    ////////////////////////////////////////////////////////////////////////
    // clock, timeout and word monitor
    always #25 clock = ~clock;
    always @(posedge clock)
    begin
        source_data <= $urandom;
        if (dest_write_en_n === 1'b0)
            got.push_back({control_flag_n, dest_data});
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            $display("Error timeout expected end seen hang");
            complete_run();
        end
    end

    task complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    task check(input string name, input logic [32:0] seen, exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // one single transfer; read data taken at the data phase's edge
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        q = hrdata;
        check("hresp", hresp, 0);
    endtask : ahb

    task reset_dut(input logic [1:0] code);
        @(posedge clock);
        nrst <= 1'b0;
        width_select <= code;
        repeat (2) @(posedge clock);
        check("return_out_rst", return_out, 0);
        nrst <= 1'b1;
        repeat (5) @(posedge clock);
    endtask : reset_dut

    // a short request gives exactly one pattern cycle of width+1 words
    task run_test(input logic fwd, input logic [1:0] code, input logic inj);
        int w, n;
        w = (code == 2'h1) ? 16 : (code == 2'h2) ? 8 : 32;
        got.delete();
        @(posedge clock);
        test_forward_n <= ~fwd;
        test_request_n <= 1'b0;
        repeat (4) @(posedge clock);
        test_request_n <= 1'b1;
        check("src_link_down", src_link_down_n, 0);
        repeat (4) @(posedge clock);
        check("dst_link_down", dst_link_down_n, 0);
        check("test_leds", {src_test_led, dst_test_led}, 3);
        check("err_entry", data_error_n, 1);
        if (inj)
        begin
            fwd_fault <= 1'b1;
            repeat (3) @(posedge clock);
            fwd_fault <= 1'b0;
            repeat (3) @(posedge clock);
            check("err_in_test", data_error_n, 0);
        end
        // forwarded words must stop while flow stop is held low
        flow_stop_n <= 1'b0;
        repeat (6) @(posedge clock);
        check("flow_paused", dest_write_en_n, 1);
        flow_stop_n <= 1'b1;
        n = 0;
        while (src_test_led !== 1'b0 && n < 400)
        begin
            @(posedge clock);
            n++;
        end
        check("test_end", src_test_led, 0);
        repeat (8) @(posedge clock);
        check("err_exit", data_error_n, 1);
        check("links_up", {src_link_down_n, dst_link_down_n}, 3);
        check("word_count", got.size(), fwd ? w + 1 : 0);
        for (int i = 0; i < got.size() && i <= w; i++)
            check("test_word", got[i],
                  (i == 0) ? 33'h0 : {1'b1, 32'h1 << (i - 1)});
        $display("test pattern code %0d done", code);
    endtask : run_test

    task make_error();
        source_write_en_n <= 1'b0;
        fwd_fault <= 1'b1;
        repeat (3) @(posedge clock);
        source_write_en_n <= 1'b1;
        fwd_fault <= 1'b0;
        repeat (8) @(posedge clock);
    endtask : make_error

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        logic [3:0] r;
        void'($urandom(17));
        ret_req = 4'h5;
        reset_dut(2'h0);
        // width is fixed at reset, later pin changes do nothing
        width_select <= 2'h1;
        ahb(0, link_selftest_pkg::STATUS_OFS, 0);
        check("width_cfg", q[5:4], 0);
        ahb(0, 8'h40, 0);
        check("unmapped", q, 0);
        $display("test registers done");
        // return lines, several skipped bad words, then persistent faults
        r = $urandom;
        r[0] = 1'b1;
        ret_req <= r;
        // far side changes level 32 link cycles after its last change,
        // so the fault below spans the change to the inverse
        @(return_in);
        repeat (28) @(posedge dest_clock);
        @(posedge clock);
        check("return_mirror", return_out, r);
        ret_fault <= 1'b1;
        ret_req <= ~r;
        repeat (40) @(posedge clock);
        check("return_bad", return_out, r);
        ret_fault <= 1'b0;
        repeat (300) @(posedge clock);
        check("return_next", return_out, r ^ 4'hf);
        ret_fault <= 1'b1;
        repeat (200) @(posedge clock);
        check("return_fail", src_link_down_n, 0);
        ret_fault <= 1'b0;
        $display("test return lines done");
        // error latch: software clear, then clear on test entry
        reset_dut(2'h0);
        make_error();
        ahb(0, link_selftest_pkg::STATUS_OFS, 0);
        check("err_status", q[2], 1);
        ahb(1, link_selftest_pkg::CTRL_OFS, 32'h1);
        repeat (2) @(posedge clock);
        check("err_cleared", data_error_n, 1);
        make_error();
        run_test(0, 2'h0, 1);
        // every width code with forwarding on
        for (int c = 0; c < 4; c++)
        begin
            reset_dut(c[1:0]);
            run_test(1, c[1:0], 0);
        end
        complete_run();
    end
endmodule : tb
